// ---- rtl/sss_bus_if.sv ----
// pins between the converter sequencer and its host
`timescale 1ns/100ps
`default_nettype none
interface sss_bus_if;
	logic conversion_start_n;
	logic [3:0] channel_select_pins;
	logic select_source;
	logic clock_source_select;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic busy;
	logic eoc_n;
	logic [13:0] dev_data;
	logic dev_oe;
	logic [3:0] host_low_data_lines;
	logic host_oe;
	logic [13:0] data_bus;
	// resolved bus level; undriven lines read as zero
	assign data_bus = dev_oe ? dev_data : {10'h000, host_oe ? host_low_data_lines : 4'h0};
	modport dev (
		input conversion_start_n, channel_select_pins, select_source, clock_source_select,
		input cs_n, rd_n, wr_n, data_bus,
		output busy, eoc_n, dev_data, dev_oe
	);
	modport host (
		output conversion_start_n, channel_select_pins, select_source, clock_source_select,
		output cs_n, rd_n, wr_n, host_low_data_lines, host_oe,
		input busy, eoc_n, data_bus
	);
endinterface
`default_nettype wire

// ---- rtl/sss_dev.sv ----
// device end: four-channel simultaneous sample and conversion sequencer
//
// Overview of operation
// - start rising edge: hold all, begin sequence
// - select source low: pins, high: register
// - host writes select register on low lines
// - selection frozen at start edge
// - busy rises at start edge, stays high
// - last channel done: busy low, tracking
// - internal timing, or external clock when selected
// - end-of-conversion marks each channel separately
// - each result readable once signalled
// - read drives result while select and strobe low
// - each channel converts in 2.4 us
// - host waits acquisition time before next start; here a start pending when busy falls goes out in that same cycle
// - host avoids reads during conversion; here it reads after each end-of-conversion, even mid-sequence
// - end-of-conversion is brief low pulse
// - register bit0 is channel one, bit3 four
// - set channels converted in ascending order
`timescale 1ns/100ps
`default_nettype none
module sss_dev
	import sss_pkg::*;
#(
	parameter int EXT_EDGES = SSS_EXT_EDGES
) (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// pins toward the host
	sss_bus_if.dev bus,
	// converter side
	input wire logic external_clock_in,
	input wire logic [3:0][13:0] sample_data,
	output logic track_hold,
	output logic [3:0] channel_register
);
	sss_dev_t r_ff;
	sss_dev_t nxt_r;
	logic start_rise;
	logic xedge;
	logic step;
	logic [1:0] low_ch;
	logic [3:0] left;
	logic [1:0] next_ch;
	logic [3:0] after;
	logic [3:0] first_now;
	logic [3:0] first_after;
	logic rd_on;

	// outputs straight from flops
	assign bus.busy = r_ff.busy;
	assign bus.eoc_n = r_ff.eoc_n;
	assign bus.dev_data = r_ff.dout;
	assign bus.dev_oe = r_ff.doe;
	assign track_hold = r_ff.hold;
	assign channel_register = r_ff.sel;

	assign start_rise = bus.conversion_start_n && !r_ff.start_q;
	// external clock edge once second and third stage agree
	assign xedge = (r_ff.xsync[1] == r_ff.xsync[2]) && r_ff.xsync[2] && !r_ff.xlvl;

	assign rd_on = !bus.cs_n && !bus.rd_n;
	// pending set once the channel in conversion is struck off
	assign after = r_ff.pending & ~(4'h1 << r_ff.ch);

	// one-hot of the lowest channel still to convert, now and after this one
	for (genvar g = 0; g < SSS_CH; g++) begin : g_pick
		if (g == 0) begin : g_base
			assign first_now[g] = r_ff.pending[g];
			assign first_after[g] = after[g];
		end else begin : g_rest
			assign first_now[g] = r_ff.pending[g] && !(|r_ff.pending[g-1:0]);
			assign first_after[g] = after[g] && !(|after[g-1:0]);
		end
	end
	// four channels fixed, so the encoder is written out
	assign low_ch = {first_now[3] | first_now[2], first_now[3] | first_now[1]};
	assign next_ch = {first_after[3] | first_after[2], first_after[3] | first_after[1]};

	always_comb begin
		nxt_r = r_ff;
		left = r_ff.pending;
		step = 1'b0;
		nxt_r.start_q = bus.conversion_start_n;
		nxt_r.xsync = {r_ff.xsync[1:0], external_clock_in};
		if (r_ff.xsync[1] == r_ff.xsync[2]) begin
			nxt_r.xlvl = r_ff.xsync[2];
		end
		nxt_r.eoc_n = 1'b1;

		// select register: low lines carry channel bits 0..3
		if (!bus.cs_n && !bus.wr_n) begin
			nxt_r.sel = bus.data_bus[3:0];
		end

		// conversion timing source
		if (bus.clock_source_select) begin
			step = xedge;
		end else begin
			step = 1'b1;
		end

		// a start edge during a sequence is dropped, not queued
		case (r_ff.state)
			SSS_D_IDLE: begin
				if (start_rise) begin
					// all channels sampled together at the start edge
					nxt_r.held = sample_data;
					nxt_r.hold = 1'b1;
					nxt_r.busy = 1'b1;
					nxt_r.wr_ptr = '0;
					nxt_r.rd_ptr = '0;
					if (bus.select_source) begin
						nxt_r.pending = r_ff.sel;
					end else begin
						nxt_r.pending = bus.channel_select_pins;
					end
					nxt_r.state = SSS_D_NEXT;
				end
			end
			SSS_D_NEXT: begin
				if (r_ff.pending == 4'h0) begin
					// empty selection ends at once
					nxt_r.busy = 1'b0;
					nxt_r.hold = 1'b0;
					nxt_r.state = SSS_D_IDLE;
				end else begin
					nxt_r.ch = low_ch;
					if (bus.clock_source_select) begin
						nxt_r.timer = 8'(EXT_EDGES);
					end else begin
						nxt_r.timer = 8'(SSS_CONV_CYC);
					end
					nxt_r.state = SSS_D_CONV;
				end
			end
			SSS_D_CONV: begin
				if (step) begin
					nxt_r.timer = r_ff.timer - 8'd1;
				end
				if (step && r_ff.timer == 8'd1) begin
					// result stored in the same cycle that it is announced
					nxt_r.results[r_ff.wr_ptr[1:0]] = r_ff.held[r_ff.ch];
					nxt_r.wr_ptr = r_ff.wr_ptr + 3'd1;
					nxt_r.eoc_n = 1'b0;
					left[r_ff.ch] = 1'b0;
					nxt_r.pending = left;
					if (left == 4'h0) begin
						nxt_r.busy = 1'b0;
						nxt_r.hold = 1'b0;
						nxt_r.state = SSS_D_IDLE;
					end else begin
						nxt_r.ch = next_ch;
						if (bus.clock_source_select) begin
							nxt_r.timer = 8'(EXT_EDGES);
						end else begin
							nxt_r.timer = 8'(SSS_CONV_CYC);
						end
					end
				end
			end
			default: begin
				nxt_r.state = SSS_D_IDLE;
			end
		endcase

		// read port: one stored result per read cycle
		nxt_r.rd_q = rd_on;
		nxt_r.doe = rd_on;
		nxt_r.dout = r_ff.results[r_ff.rd_ptr[1:0]];
		// pointer steps at the end of a read, never past what was written;
		// a read beyond the last result repeats a stale slot
		if (r_ff.rd_q && !rd_on && !start_rise) begin
			if (r_ff.rd_ptr != r_ff.wr_ptr) begin
				nxt_r.rd_ptr = r_ff.rd_ptr + 3'd1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= SSS_DEV_RST;
		end else if (clk_en) begin
			r_ff <= nxt_r;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/sss_host.sv ----
// host end: APB-programmed controller driving the converter pins
`timescale 1ns/100ps
`default_nettype none
module sss_host
	import sss_pkg::*;
(
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// pins toward the device
	sss_bus_if.host bus
);
	sss_host_t r_ff;
	sss_host_t nxt_r;
	logic wr_acc;
	logic busy_fall;
	logic eoc_fall;
	logic [2:0] ev;

	assign prdata = r_ff.prdata;
	assign pready = r_ff.pready;
	assign pslverr = r_ff.pslverr;
	assign irq = r_ff.irq;
	assign bus.conversion_start_n = r_ff.conversion_start_n_n;
	assign bus.channel_select_pins = r_ff.pins;
	assign bus.select_source = r_ff.sel_src;
	assign bus.clock_source_select = r_ff.clk_src;
	assign bus.cs_n = r_ff.cs_n;
	assign bus.rd_n = r_ff.rd_n;
	assign bus.wr_n = r_ff.wr_n;
	assign bus.host_low_data_lines = r_ff.lo;
	assign bus.host_oe = r_ff.lo_oe;

	assign wr_acc = psel && penable && r_ff.pready && pwrite;
	assign busy_fall = r_ff.busy_q && !bus.busy;
	assign eoc_fall = r_ff.eoc_q && !bus.eoc_n;

	always_comb begin
		nxt_r = r_ff;
		ev = 3'b000;
		nxt_r.busy_q = bus.busy;
		nxt_r.eoc_q = bus.eoc_n;
		if (eoc_fall) begin
			nxt_r.eoc_seen = 1'b1;
		end
		if (r_ff.guard != 8'd0) begin
			nxt_r.guard = r_ff.guard - 8'd1;
		end
		if (busy_fall) begin
			nxt_r.guard = 8'(SSS_ACQ_CYC);
		end
		ev[SSS_IRQ_EOC] = eoc_fall;
		ev[SSS_IRQ_DONE] = busy_fall;

		// setup phase prepares the answer; access phase carries pready
		nxt_r.pready = psel && !penable;
		nxt_r.pslverr = 1'b0;
		if (psel && !penable) begin
			nxt_r.prdata = 32'h0000_0000;
			if (paddr == SSS_CTRL_OFS) begin
				nxt_r.prdata = {24'h000000, r_ff.pins, 2'b00, r_ff.clk_src, r_ff.sel_src};
			end else if (paddr == SSS_CMD_OFS) begin
				nxt_r.prdata = {29'h00000000, r_ff.req};
			end else if (paddr == SSS_STAT_OFS) begin
				nxt_r.prdata = {24'h000000, r_ff.chsel, r_ff.eoc_seen,
					r_ff.state == SSS_H_IDLE, r_ff.guard == 8'd0, bus.busy};
			end else if (paddr == SSS_RDATA_OFS) begin
				nxt_r.prdata = {18'h00000, r_ff.rdata};
			end else if (paddr == SSS_ISTAT_OFS) begin
				nxt_r.prdata = {29'h00000000, r_ff.ist};
			end else if (paddr == SSS_IMASK_OFS) begin
				nxt_r.prdata = {29'h00000000, r_ff.imask};
			end else begin
				nxt_r.pslverr = 1'b1;
			end
		end
		if (wr_acc) begin
			if (paddr == SSS_CTRL_OFS) begin
				nxt_r.sel_src = pwdata[SSS_CTRL_SRC];
				nxt_r.clk_src = pwdata[SSS_CTRL_CLK];
				nxt_r.pins = pwdata[SSS_CTRL_PINS +: 4];
			end else if (paddr == SSS_CMD_OFS) begin
				if (pwdata[SSS_CMD_WRSEL]) begin
					nxt_r.chsel = pwdata[SSS_CMD_VAL +: 4];
				end
			end else if (paddr == SSS_IMASK_OFS) begin
				nxt_r.imask = pwdata[2:0];
			end
		end

		case (r_ff.state)
			SSS_H_IDLE: begin
				nxt_r.cnt = 4'd0;
				if (r_ff.req[SSS_CMD_WRSEL]) begin
					nxt_r.req[SSS_CMD_WRSEL] = 1'b0;
					nxt_r.cs_n = 1'b0;
					nxt_r.wr_n = 1'b0;
					nxt_r.lo = r_ff.chsel;
					nxt_r.lo_oe = 1'b1;
					nxt_r.state = SSS_H_WR;
				end else if (r_ff.req[SSS_CMD_START] && !bus.busy && r_ff.guard == 8'd0) begin
					nxt_r.req[SSS_CMD_START] = 1'b0;
					nxt_r.conversion_start_n_n = 1'b0;
					nxt_r.state = SSS_H_START;
				end else if (r_ff.req[SSS_CMD_READ] && (!bus.busy || r_ff.eoc_seen)) begin
					// reads when idle, or mid-sequence once an end of conversion is seen
					nxt_r.req[SSS_CMD_READ] = 1'b0;
					nxt_r.eoc_seen = eoc_fall;
					nxt_r.cs_n = 1'b0;
					nxt_r.rd_n = 1'b0;
					nxt_r.state = SSS_H_RD;
				end
			end
			SSS_H_START: begin
				nxt_r.cnt = r_ff.cnt + 4'd1;
				if (r_ff.cnt == 4'(SSS_START_LOW_CYC - 1)) begin
					nxt_r.conversion_start_n_n = 1'b1;
					nxt_r.eoc_seen = 1'b0;
					nxt_r.state = SSS_H_IDLE;
				end
			end
			SSS_H_WR: begin
				nxt_r.cnt = r_ff.cnt + 4'd1;
				if (r_ff.cnt == 4'(SSS_STROBE_CYC - 1)) begin
					nxt_r.cs_n = 1'b1;
					nxt_r.wr_n = 1'b1;
					nxt_r.state = SSS_H_GAP;
				end
			end
			SSS_H_RD: begin
				nxt_r.cnt = r_ff.cnt + 4'd1;
				if (r_ff.cnt == 4'(SSS_STROBE_CYC - 1)) begin
					nxt_r.rdata = bus.data_bus;
					nxt_r.cs_n = 1'b1;
					nxt_r.rd_n = 1'b1;
					nxt_r.guard = (nxt_r.guard > 8'(SSS_QUIET_CYC)) ? nxt_r.guard
						: 8'(SSS_QUIET_CYC);
					ev[SSS_IRQ_RD] = 1'b1;
					nxt_r.state = SSS_H_IDLE;
				end
			end
			SSS_H_GAP: begin
				// lines released one cycle after the strobe rises
				nxt_r.lo_oe = 1'b0;
				nxt_r.state = SSS_H_IDLE;
			end
			default: begin
				nxt_r.state = SSS_H_IDLE;
			end
		endcase

		// a request written while an older one is served stays pending
		if (wr_acc && paddr == SSS_CMD_OFS) begin
			nxt_r.req = nxt_r.req | pwdata[2:0];
		end

		// write-one-to-clear; a new event wins over the clear
		if (wr_acc && paddr == SSS_ISTAT_OFS) begin
			nxt_r.ist = r_ff.ist & ~pwdata[2:0];
		end
		nxt_r.ist = nxt_r.ist | ev;
		nxt_r.irq = |(nxt_r.ist & nxt_r.imask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= SSS_HOST_RST;
		end else if (clk_en) begin
			r_ff <= nxt_r;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/sss_pkg.sv ----
// shared constants, types and reset values of the simultaneous sample sequencer
package sss_pkg;
	localparam int SSS_CH = 4;
	localparam int SSS_DW = 14;
	localparam int SSS_CLK_NS = 10;
	// per-channel conversion time and acquisition time
	localparam int SSS_CONV_NS = 2400;
	localparam int SSS_ACQ_NS = 350;
	localparam int SSS_QUIET_NS = 100;
	localparam int SSS_CONV_CYC = (SSS_CONV_NS + SSS_CLK_NS - 1) / SSS_CLK_NS;
	localparam int SSS_ACQ_CYC = (SSS_ACQ_NS + SSS_CLK_NS - 1) / SSS_CLK_NS;
	localparam int SSS_QUIET_CYC = (SSS_QUIET_NS + SSS_CLK_NS - 1) / SSS_CLK_NS;
	localparam int SSS_EXT_EDGES = 16;
	localparam int SSS_STROBE_CYC = 3;
	localparam int SSS_START_LOW_CYC = 2;
	// host register offsets
	localparam logic [7:0] SSS_CTRL_OFS = 8'h00;
	localparam logic [7:0] SSS_CMD_OFS = 8'h04;
	localparam logic [7:0] SSS_STAT_OFS = 8'h08;
	localparam logic [7:0] SSS_RDATA_OFS = 8'h0C;
	localparam logic [7:0] SSS_ISTAT_OFS = 8'h10;
	localparam logic [7:0] SSS_IMASK_OFS = 8'h14;
	// field positions
	localparam int SSS_CTRL_SRC = 0;
	localparam int SSS_CTRL_CLK = 1;
	localparam int SSS_CTRL_PINS = 4;
	localparam int SSS_CMD_START = 0;
	localparam int SSS_CMD_WRSEL = 1;
	localparam int SSS_CMD_READ = 2;
	localparam int SSS_CMD_VAL = 4;
	localparam int SSS_IRQ_EOC = 0;
	localparam int SSS_IRQ_DONE = 1;
	localparam int SSS_IRQ_RD = 2;

	typedef enum logic [1:0] {SSS_D_IDLE, SSS_D_CONV, SSS_D_NEXT} sss_dev_state_t;
	typedef enum logic [2:0] {SSS_H_IDLE, SSS_H_START, SSS_H_WR, SSS_H_RD, SSS_H_GAP} sss_host_state_t;

	typedef struct packed {
		sss_dev_state_t state;
		logic start_q;
		logic [2:0] xsync;
		logic xlvl;
		logic [3:0] sel;
		logic [3:0] pending;
		logic [1:0] ch;
		logic [7:0] timer;
		logic [3:0][13:0] held;
		logic [3:0][13:0] results;
		logic [2:0] wr_ptr;
		logic [2:0] rd_ptr;
		logic rd_q;
		logic busy;
		logic eoc_n;
		logic hold;
		logic [13:0] dout;
		logic doe;
	} sss_dev_t;

	typedef struct packed {
		sss_host_state_t state;
		logic [7:0] guard;
		logic [3:0] cnt;
		logic conversion_start_n_n;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [3:0] lo;
		logic lo_oe;
		logic sel_src;
		logic clk_src;
		logic [3:0] pins;
		logic [3:0] chsel;
		logic [13:0] rdata;
		logic eoc_seen;
		logic busy_q;
		logic eoc_q;
		logic [2:0] req;
		logic [2:0] ist;
		logic [2:0] imask;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sss_host_t;

	localparam sss_dev_t SSS_DEV_RST = '{state: SSS_D_IDLE, start_q: 1'b1, eoc_n: 1'b1,
		default: '0};
	localparam sss_host_t SSS_HOST_RST = '{state: SSS_H_IDLE, conversion_start_n_n: 1'b1, cs_n: 1'b1,
		rd_n: 1'b1, wr_n: 1'b1, default: '0};
endpackage

// ---- test/sss_monitor.sv ----
// assertion checker on the pins between host and device
`timescale 1ns/100ps
`default_nettype none
module sss_monitor
	import sss_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins
	input wire logic conversion_start_n,
	input wire logic clock_source_select,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic busy,
	input wire logic eoc_n,
	input wire logic dev_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	int acq_gap;
	int rd_gap;

	// cycles since the sequence ended and since the last read strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acq_gap <= SSS_ACQ_CYC;
			rd_gap <= SSS_QUIET_CYC;
		end else begin
			if (busy) begin
				acq_gap <= 0;
			end else if (acq_gap < SSS_ACQ_CYC) begin
				acq_gap <= acq_gap + 1;
			end
			if (!rd_n) begin
				rd_gap <= 0;
			end else if (rd_gap < SSS_QUIET_CYC) begin
				rd_gap <= rd_gap + 1;
			end
		end
	end

	start_busy_a: assert property ($rose(conversion_start_n) && !busy |=> busy)
		else $error("busy did not follow start");
	busy_hold_a: assert property ($rose(busy) |-> busy[*8])
		else $error("busy dropped early");
	busy_end_a: assert property ($fell(busy) |-> !eoc_n)
		else $error("busy fell without end of conversion");
	eoc_pulse_a: assert property (!eoc_n |=> eoc_n)
		else $error("end of conversion pulse too long");
	eoc_busy_a: assert property (!eoc_n |-> busy || $past(busy))
		else $error("end of conversion outside sequence");
	conv_first_a: assert property ($rose(busy) && !clock_source_select |-> ##[238:243] !eoc_n)
		else $error("first conversion time wrong");
	conv_next_a: assert property (!eoc_n && busy && !clock_source_select |-> ##240 !eoc_n)
		else $error("channel conversion time wrong");
	read_drive_a: assert property ($fell(rd_n) && !cs_n |=> dev_oe)
		else $error("device did not drive read data");
	read_release_a: assert property (cs_n && $past(cs_n) |-> !dev_oe)
		else $error("device drives bus when not selected");
	write_quiet_a: assert property (!cs_n && !wr_n |-> !dev_oe)
		else $error("device drives bus during write");
	acq_wait_a: assert property ($fell(conversion_start_n) |-> acq_gap >= SSS_ACQ_CYC)
		else $error("start issued inside acquisition time");
	rd_quiet_a: assert property ($rose(conversion_start_n) |-> rd_gap >= SSS_QUIET_CYC)
		else $error("read too close to start edge");

	cover property ($fell(busy));
	cover property ($fell(rd_n) && !cs_n);
	cover property (!cs_n && !wr_n);
	cover property ($fell(rd_n) && !cs_n && busy);
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for host and device joined pin to pin
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import sss_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic ext_clk = 1'b0;
	logic ext_run = 1'b0;
	logic en = 1'b1;
	logic track_hold;
	logic th;
	logic err;
	logic [3:0] chreg;
	logic [3:0] wr_lines = 4'h0;
	logic [31:0] rd;
	logic [3:0][13:0] samp = {14'h3ABC, 14'h2D4E, 14'h1F20, 14'h0A51};
	int fail_count = 0;
	int n_checks = 0;
	int eoc_cnt = 0;
	int bl;
	int c;

	sss_bus_if bus ();
	sss_host sss_host_i (.pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .bus(bus.host));
	// two external edges keep the slow-clock run short
	sss_dev #(.EXT_EDGES(2)) sss_dev_i (.pclk(pclk), .presetn(presetn), .clk_en(en),
		.bus(bus.dev), .external_clock_in(ext_clk), .sample_data(samp),
		.track_hold(track_hold), .channel_register(chreg));
	sss_monitor sss_monitor_i (.pclk(pclk), .presetn(presetn),
		.conversion_start_n(bus.conversion_start_n),
		.clock_source_select(bus.clock_source_select), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
		.wr_n(bus.wr_n), .busy(bus.busy), .eoc_n(bus.eoc_n), .dev_oe(bus.dev_oe));

	always #5 pclk = ~pclk;
	// external clock only runs while a scenario asks for it
	always #17 ext_clk = ext_run ? ~ext_clk : 1'b0;
	always @(posedge pclk) begin
		if (bus.eoc_n === 1'b0) begin
			eoc_cnt <= eoc_cnt + 1;
		end
		if (bus.cs_n === 1'b0 && bus.wr_n === 1'b0) begin
			wr_lines <= bus.data_bus[3:0];
		end
	end

	task automatic stop_test();
		if (fail_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// bl ends as the number of cycles spent waiting
	task automatic wait_lvl(input logic v);
		bl = 0;
		while (bus.busy !== v) begin
			bl++;
			@(posedge pclk);
		end
		th = track_hold;
	endtask

	task automatic start_seq();
		c = eoc_cnt;
		apb(1'b1, SSS_CMD_OFS, 32'h1);
		wait_lvl(1'b1);
	endtask

	task automatic get_res(input logic [13:0] exp);
		apb(1'b1, SSS_CMD_OFS, 32'h4);
		rd = 32'h0;
		while (rd[SSS_IRQ_RD] !== 1'b1) begin
			apb(1'b0, SSS_ISTAT_OFS, 32'h0);
		end
		apb(1'b1, SSS_ISTAT_OFS, 32'h4);
		apb(1'b0, SSS_RDATA_OFS, 32'h0);
		chk(rd[13:0], exp, "result");
	endtask

	task automatic t_pins();
		apb(1'b1, SSS_CTRL_OFS, 32'hA0);
		start_seq();
		chk(th, 1'b1, "hold at start");
		wait_lvl(1'b0);
		chk(bl >= 2 * SSS_CONV_CYC && bl <= 2 * SSS_CONV_CYC + 2, 1'b1, "busy span");
		chk(track_hold, 1'b0, "tracking after end");
		apb(1'b0, SSS_STAT_OFS, 32'h0);
		chk(rd[7:0], 8'h0C, "status after end");
		get_res(samp[1]);
		get_res(samp[3]);
		chk(eoc_cnt - c, 2, "eoc count");
	endtask

	task automatic t_reg();
		apb(1'b1, SSS_CTRL_OFS, 32'h21);
		apb(1'b1, SSS_CMD_OFS, 32'hD2);
		start_seq();
		chk(wr_lines, 4'hD, "low lines");
		apb(1'b1, SSS_CMD_OFS, 32'h22);
		wait_lvl(1'b0);
		get_res(samp[0]);
		get_res(samp[2]);
		get_res(samp[3]);
		chk(eoc_cnt - c, 3, "frozen selection");
		chk(chreg, 4'h2, "select register");
		start_seq();
		wait_lvl(1'b0);
		get_res(samp[1]);
		chk(eoc_cnt - c, 1, "new selection");
	endtask

	task automatic t_ext();
		apb(1'b1, SSS_CTRL_OFS, 32'h12);
		start_seq();
		repeat (300) @(posedge pclk);
		chk(eoc_cnt - c, 0, "stalled clock");
		en <= 1'b0;
		ext_run = 1'b1;
		repeat (100) @(posedge pclk);
		chk(eoc_cnt - c, 0, "frozen by enable");
		chk(bus.busy, 1'b1, "busy while frozen");
		en <= 1'b1;
		wait_lvl(1'b0);
		ext_run = 1'b0;
		get_res(samp[0]);
		chk(eoc_cnt - c, 1, "external clock");
	endtask

	task automatic t_live();
		apb(1'b1, SSS_CTRL_OFS, 32'h60);
		start_seq();
		get_res(samp[1]);
		chk(bus.busy, 1'b1, "read inside sequence");
		get_res(samp[2]);
		chk(eoc_cnt - c, 2, "one read per result");
	endtask

	task automatic t_irq();
		apb(1'b1, SSS_ISTAT_OFS, 32'h7);
		apb(1'b1, SSS_CTRL_OFS, 32'h80);
		start_seq();
		wait_lvl(1'b0);
		apb(1'b0, SSS_ISTAT_OFS, 32'h0);
		chk(rd[1:0], 2'b11, "status");
		chk(irq, 1'b0, "masked irq");
		apb(1'b1, SSS_IMASK_OFS, 32'h2);
		@(posedge pclk);
		chk(irq, 1'b1, "irq raised");
		apb(1'b1, SSS_ISTAT_OFS, 32'h2);
		@(posedge pclk);
		chk(irq, 1'b0, "irq cleared");
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 1'b1, "unmapped");
	endtask

	initial begin
		#200000;
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_pins();
		t_reg();
		t_ext();
		t_live();
		t_irq();
		stop_test();
	end
endmodule
`default_nettype wire
